// ==== hw/io_port_pkg.sv ====
// Shared constants and carrier types for the I/O port access unit
package io_port_pkg;

   // Register word offsets (byte addresses on APB)
   localparam logic [7:0] CTRL_OFS     = 8'h00;
   localparam logic [7:0] STATUS_OFS   = 8'h04;
   localparam logic [7:0] PORT_OFS     = 8'h08;
   localparam logic [7:0] ACC_OFS      = 8'h0C;
   localparam logic [7:0] SRC_IDX_OFS  = 8'h10;
   localparam logic [7:0] DST_IDX_OFS  = 8'h14;
   localparam logic [7:0] SRC_SEG_OFS  = 8'h18;
   localparam logic [7:0] DST_SEG_OFS  = 8'h1C;
   localparam logic [7:0] COUNT_OFS    = 8'h20;
   localparam logic [7:0] FLAGS_OFS    = 8'h24;
   localparam logic [7:0] TSB_BASE_OFS = 8'h28;
   localparam logic [7:0] TSB_MAP_OFS  = 8'h2C;

   // Control word fields
   localparam int CTRL_START = 0;
   localparam int CTRL_WRITE = 1;
   localparam int CTRL_SIZE  = 2;
   localparam int CTRL_STR   = 4;
   localparam int CTRL_REP   = 5;
   localparam int CTRL_IMM   = 6;
   localparam int CTRL_PCO   = 7;

   // Status word fields
   localparam int STAT_BUSY   = 0;
   localparam int STAT_DONE   = 1;
   localparam int STAT_FAULT  = 2;
   localparam int STAT_PARITY = 3;

   // Flags word fields
   localparam int FLG_DIR   = 0;
   localparam int FLG_IOPRV = 1;
   localparam int FLG_CUPRV = 3;
   localparam int FLG_PMODE = 5;

   // Item size codes
   localparam logic [1:0] SIZE_8  = 2'h0;
   localparam logic [1:0] SIZE_16 = 2'h1;
   localparam logic [1:0] SIZE_32 = 2'h2;

   // Port space is 64K byte ports, 0 through FFFFH
   localparam logic [15:0] PORT_MAX = 16'hFFFF;
   localparam logic [31:0] WORD_STEP = 32'h0000_0004;

   typedef enum logic [2:0] {
      S_IDLE, S_BEGIN, S_PERM, S_MEMRD, S_PORTRD, S_PORTWR, S_MEMWR, S_NEXT
   } fsm_t;

   typedef struct packed {
      logic        req;
      logic        mem_io;
      logic        cache_ok;
      logic        we;
      logic [31:0] addr;
      logic [3:0]  be;
      logic [31:0] wdata;
   } bus_out_t;

   typedef struct packed {
      logic        ack;
      logic        parity_err;
      logic        cache_allow_n;
      logic [31:0] rdata;
   } bus_in_t;

   localparam int BUS_IN_W = 35;

endpackage

// ==== hw/sync2.sv ====
// Two-stage synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
`default_nettype none

module sync2 #(
   parameter int W = 1
) (
   input  wire logic         mclk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output var  logic [W-1:0] q
);

   logic [W-1:0] meta_ff;

   // The first stage feeds only the second stage
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         meta_ff <= '0;
         q       <= '0;
      end else begin
         meta_ff <= d;
         q       <= meta_ff;
      end
   end

endmodule

`default_nettype wire

// ==== hw/io_port_access_unit.sv ====
// I/O port access unit: APB register file, protection check and bus cycle engine
`timescale 1ns/1ps
`default_nettype none

// Contract
// - An I/O write finishes its bus cycle before the unit reports done.
// - Memory/IO select pin is 1 for memory cycles, 0 for I/O cycles.
// - Port space holds 64K byte ports, numbered zero through FFFFH.
// - Two or four consecutive byte ports form a 16 or 32 bit port.
// - Aligned 16 or 32 bit ports move in a single bus cycle.
// - Misaligned ports still transfer; one that crosses a 4-byte boundary uses an extra bus cycle.
// - Split cycle order is unspecified; ordered writes need separate accesses.
// - Parity errors on I/O cycles are reported, never masked.
// - While cache allow input is high, no address is cached.
// - A page cache off flag suppresses caching for that access.
// - Port accesses produce only I/O cycles; string data and bitmap reads use memory cycles.
// - Single port transfers use acc32, acc16 or acc8; port from immediate or index.
// - String ports use port index; memory via source or destination segment and index.
// - After each repeated item the index rises if direction clear, else falls.
// - Protected mode checks privilege field and the task block permission bitmap.
// - Privilege above the field without bitmap grant faults instead of accessing.
// - Every bitmap bit of the port bytes is tested; any set bit faults.
module io_port_access_unit (
   input  wire logic                 mclk,
   input  wire logic                 rst_n,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [7:0]           paddr,
   input  wire logic [31:0]          pwdata,
   output var  logic [31:0]          prdata,
   output var  logic                 pready,
   output var  logic                 pslverr,
   input  wire io_port_pkg::bus_in_t bus_in,
   output var  io_port_pkg::bus_out_t bus_out
);

   typedef struct packed {
      io_port_pkg::fsm_t     state;
      logic [1:0]            size;
      logic                  we_out;
      logic                  str;
      logic                  repeat_prefix;
      logic                  imm;
      logic                  page_cache_off;
      logic [15:0]           port_index_reg;
      logic [15:0]           port_imm;
      logic [31:0]           acc32;
      logic [31:0]           source_index;
      logic [31:0]           dest_index;
      logic [31:0]           source_segment;
      logic [31:0]           dest_segment;
      logic [31:0]           count;
      logic                  direction_flag;
      logic [1:0]            io_privilege_field;
      logic [1:0]            current_privilege;
      logic                  pmode;
      logic [31:0]           tsb_base;
      logic [15:0]           map_base;
      logic [15:0]           tsb_limit;
      logic                  busy;
      logic                  done;
      logic                  fault;
      logic                  parity;
      logic                  part;
      logic [31:0]           asm_lo;
      logic [31:0]           item;
      io_port_pkg::bus_out_t bus;
      logic [31:0]           prdata;
      logic                  pready;
      logic                  pslverr;
   } state_t;

   state_t               st;
   state_t               nxt_st;
   io_port_pkg::bus_in_t in_s;

   // Pins come from the far side of the processor bus
   sync2 #(.W(io_port_pkg::BUS_IN_W)) u_sync (
      .mclk  (mclk),
      .rst_n (rst_n),
      .d     (bus_in),
      .q     (in_s)
   );

   function automatic logic [2:0] nbytes(input logic [1:0] sz);
      case (sz)
         io_port_pkg::SIZE_8:  nbytes = 3'h1;
         io_port_pkg::SIZE_16: nbytes = 3'h2;
         default:              nbytes = 3'h4;
      endcase
   endfunction

   function automatic logic [3:0] bit_mask(input logic [2:0] nb);
      bit_mask = 4'(8'h0F >> (3'h4 - nb));
   endfunction

   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = (a[1:0] == 2'h0) && (a <= io_port_pkg::TSB_MAP_OFS);
   endfunction

   logic [2:0]        nb;
   logic [15:0]       port;
   logic [16:0]       map_off;
   logic              need_perm;
   io_port_pkg::fsm_t first_st;
   logic              active;
   logic [31:0]       a_addr;
   logic [2:0]        a_n;
   logic              a_we;
   logic              a_mio;
   logic [31:0]       a_wd;
   logic [7:0]        lanes;
   logic [63:0]       wide;
   logic [63:0]       full64;
   logic [31:0]       res;
   logic [31:0]       cyc_addr;
   logic [15:0]       bm_bits;
   logic              last;

   always_comb begin
      nxt_st    = st;
      nb        = nbytes(st.size);
      port      = st.imm ? st.port_imm : st.port_index_reg;
      map_off   = {1'b0, st.map_base} + {4'h0, port[15:3]};
      need_perm = st.pmode && (st.current_privilege > st.io_privilege_field);
      // String ports always take the port from the index register
      if (st.str) begin
         port    = st.port_index_reg;
         map_off = {1'b0, st.map_base} + {4'h0, port[15:3]};
      end
      first_st = st.we_out ? (st.str ? io_port_pkg::S_MEMRD : io_port_pkg::S_PORTWR)
                           : io_port_pkg::S_PORTRD;

      // APB: response prepared in the setup cycle, so the access phase ends at once
      nxt_st.pready  = 1'b0;
      nxt_st.pslverr = 1'b0;
      if (psel && !penable) begin
         nxt_st.pready  = 1'b1;
         nxt_st.pslverr = !is_mapped(paddr) || (pwrite && st.busy);
         nxt_st.prdata  = 32'h0000_0000;
         if (paddr == io_port_pkg::CTRL_OFS) begin
            nxt_st.prdata[io_port_pkg::CTRL_WRITE] = st.we_out;
            nxt_st.prdata[io_port_pkg::CTRL_SIZE +: 2] = st.size;
            nxt_st.prdata[io_port_pkg::CTRL_STR] = st.str;
            nxt_st.prdata[io_port_pkg::CTRL_REP] = st.repeat_prefix;
            nxt_st.prdata[io_port_pkg::CTRL_IMM] = st.imm;
            nxt_st.prdata[io_port_pkg::CTRL_PCO] = st.page_cache_off;
         end else if (paddr == io_port_pkg::STATUS_OFS) begin
            nxt_st.prdata[io_port_pkg::STAT_BUSY]   = st.busy;
            nxt_st.prdata[io_port_pkg::STAT_DONE]   = st.done;
            nxt_st.prdata[io_port_pkg::STAT_FAULT]  = st.fault;
            nxt_st.prdata[io_port_pkg::STAT_PARITY] = st.parity;
         end else if (paddr == io_port_pkg::PORT_OFS) begin
            nxt_st.prdata = {st.port_imm, st.port_index_reg};
         end else if (paddr == io_port_pkg::ACC_OFS) begin
            nxt_st.prdata = st.acc32;
         end else if (paddr == io_port_pkg::SRC_IDX_OFS) begin
            nxt_st.prdata = st.source_index;
         end else if (paddr == io_port_pkg::DST_IDX_OFS) begin
            nxt_st.prdata = st.dest_index;
         end else if (paddr == io_port_pkg::SRC_SEG_OFS) begin
            nxt_st.prdata = st.source_segment;
         end else if (paddr == io_port_pkg::DST_SEG_OFS) begin
            nxt_st.prdata = st.dest_segment;
         end else if (paddr == io_port_pkg::COUNT_OFS) begin
            nxt_st.prdata = st.count;
         end else if (paddr == io_port_pkg::FLAGS_OFS) begin
            nxt_st.prdata[io_port_pkg::FLG_DIR] = st.direction_flag;
            nxt_st.prdata[io_port_pkg::FLG_IOPRV +: 2] = st.io_privilege_field;
            nxt_st.prdata[io_port_pkg::FLG_CUPRV +: 2] = st.current_privilege;
            nxt_st.prdata[io_port_pkg::FLG_PMODE] = st.pmode;
         end else if (paddr == io_port_pkg::TSB_BASE_OFS) begin
            nxt_st.prdata = st.tsb_base;
         end else if (paddr == io_port_pkg::TSB_MAP_OFS) begin
            nxt_st.prdata = {st.tsb_limit, st.map_base};
         end
      end

      // Writes are refused while busy so a running command sees stable operands
      if (psel && penable && st.pready && pwrite && !st.pslverr) begin
         if (paddr == io_port_pkg::CTRL_OFS) begin
            nxt_st.we_out         = pwdata[io_port_pkg::CTRL_WRITE];
            nxt_st.size           = pwdata[io_port_pkg::CTRL_SIZE +: 2];
            nxt_st.str            = pwdata[io_port_pkg::CTRL_STR];
            nxt_st.repeat_prefix  = pwdata[io_port_pkg::CTRL_REP];
            nxt_st.imm            = pwdata[io_port_pkg::CTRL_IMM];
            nxt_st.page_cache_off = pwdata[io_port_pkg::CTRL_PCO];
            if (pwdata[io_port_pkg::CTRL_START]) begin
               nxt_st.busy  = 1'b1;
               nxt_st.done  = 1'b0;
               nxt_st.state = io_port_pkg::S_BEGIN;
            end
         end else if (paddr == io_port_pkg::STATUS_OFS) begin
            nxt_st.done   = st.done & ~pwdata[io_port_pkg::STAT_DONE];
            nxt_st.fault  = st.fault & ~pwdata[io_port_pkg::STAT_FAULT];
            nxt_st.parity = st.parity & ~pwdata[io_port_pkg::STAT_PARITY];
         end else if (paddr == io_port_pkg::PORT_OFS) begin
            nxt_st.port_index_reg = pwdata[15:0];
            nxt_st.port_imm       = pwdata[31:16];
         end else if (paddr == io_port_pkg::ACC_OFS) begin
            nxt_st.acc32 = pwdata;
         end else if (paddr == io_port_pkg::SRC_IDX_OFS) begin
            nxt_st.source_index = pwdata;
         end else if (paddr == io_port_pkg::DST_IDX_OFS) begin
            nxt_st.dest_index = pwdata;
         end else if (paddr == io_port_pkg::SRC_SEG_OFS) begin
            nxt_st.source_segment = pwdata;
         end else if (paddr == io_port_pkg::DST_SEG_OFS) begin
            nxt_st.dest_segment = pwdata;
         end else if (paddr == io_port_pkg::COUNT_OFS) begin
            nxt_st.count = pwdata;
         end else if (paddr == io_port_pkg::FLAGS_OFS) begin
            nxt_st.direction_flag     = pwdata[io_port_pkg::FLG_DIR];
            nxt_st.io_privilege_field = pwdata[io_port_pkg::FLG_IOPRV +: 2];
            nxt_st.current_privilege  = pwdata[io_port_pkg::FLG_CUPRV +: 2];
            nxt_st.pmode              = pwdata[io_port_pkg::FLG_PMODE];
         end else if (paddr == io_port_pkg::TSB_BASE_OFS) begin
            nxt_st.tsb_base = pwdata;
         end else if (paddr == io_port_pkg::TSB_MAP_OFS) begin
            nxt_st.map_base  = pwdata[15:0];
            nxt_st.tsb_limit = pwdata[31:16];
         end
      end

      // Parameters of the access that the current state performs
      active = 1'b1;
      a_addr = 32'h0000_0000;
      a_n    = nb;
      a_we   = 1'b0;
      a_mio  = 1'b1;
      a_wd   = 32'h0000_0000;
      case (st.state)
         io_port_pkg::S_PERM: begin
            a_addr = st.tsb_base + {15'h0000, map_off};
            a_n    = 3'h2;  // two map bytes cover any port span
         end
         io_port_pkg::S_MEMRD: begin
            a_addr = st.source_segment + st.source_index;
         end
         io_port_pkg::S_MEMWR: begin
            a_addr = st.dest_segment + st.dest_index;
            a_we   = 1'b1;
            a_wd   = st.item;
         end
         io_port_pkg::S_PORTRD: begin
            a_addr = {16'h0000, port};
            a_mio  = 1'b0;
         end
         io_port_pkg::S_PORTWR: begin
            a_addr = {16'h0000, port};
            a_mio  = 1'b0;
            a_we   = 1'b1;
            a_wd   = st.str ? st.item : st.acc32;
         end
         default: begin
            active = 1'b0;
         end
      endcase

      // Bytes of a port map onto lanes; a span past lane 3 needs a second cycle
      lanes    = 8'(bit_mask(a_n)) << a_addr[1:0];
      wide     = {32'h0000_0000, a_wd} << {a_addr[1:0], 3'b000};
      cyc_addr = {a_addr[31:2], 2'b00} + (st.part ? io_port_pkg::WORD_STEP : 32'h0000_0000);
      if (!a_mio) begin
         cyc_addr[31:16] = 16'h0000;
      end
      full64  = st.part ? {in_s.rdata, st.asm_lo} : {32'h0000_0000, in_s.rdata};
      res     = 32'(full64 >> {a_addr[1:0], 3'b000});
      bm_bits = res[15:0] >> port[2:0];
      last    = 1'b0;

      // Four-phase handshake: raise only once the previous acknowledge has gone
      if (active && !st.bus.req && !in_s.ack) begin
         nxt_st.bus.req      = 1'b1;
         nxt_st.bus.addr     = cyc_addr;
         nxt_st.bus.mem_io   = a_mio;
         nxt_st.bus.we       = a_we;
         nxt_st.bus.be       = st.part ? lanes[7:4] : lanes[3:0];
         nxt_st.bus.wdata    = st.part ? wide[63:32] : wide[31:0];
         nxt_st.bus.cache_ok = a_mio && !in_s.cache_allow_n && !st.page_cache_off;
      end
      if (active && st.bus.req && in_s.ack) begin
         nxt_st.bus.req = 1'b0;
         if (in_s.parity_err) begin
            nxt_st.parity = 1'b1;
         end
         // Low part always goes first; software needing order splits accesses
         if (!st.part && (lanes[7:4] != 4'h0)) begin
            nxt_st.part   = 1'b1;
            nxt_st.asm_lo = in_s.rdata;
         end else begin
            nxt_st.part = 1'b0;
            last        = 1'b1;
         end
      end

      case (st.state)
         io_port_pkg::S_BEGIN: begin
            if (st.str && st.repeat_prefix && (st.count == 32'h0000_0000)) begin
               nxt_st.state = io_port_pkg::S_IDLE;
               nxt_st.busy  = 1'b0;
               nxt_st.done  = 1'b1;
            end else if (need_perm && ((map_off + 17'h00001) > {1'b0, st.tsb_limit})) begin
               nxt_st.state = io_port_pkg::S_IDLE;
               nxt_st.busy  = 1'b0;
               nxt_st.fault = 1'b1;
            end else if (need_perm) begin
               nxt_st.state = io_port_pkg::S_PERM;
            end else begin
               nxt_st.state = first_st;
            end
         end
         io_port_pkg::S_PERM: begin
            if (last && ((bm_bits[3:0] & bit_mask(nb)) != 4'h0)) begin
               nxt_st.state = io_port_pkg::S_IDLE;
               nxt_st.busy  = 1'b0;
               nxt_st.fault = 1'b1;
            end else if (last) begin
               nxt_st.state = first_st;
            end
         end
         io_port_pkg::S_MEMRD: begin
            if (last) begin
               nxt_st.item  = res;
               nxt_st.state = io_port_pkg::S_PORTWR;
            end
         end
         io_port_pkg::S_PORTRD: begin
            if (last && st.str) begin
               nxt_st.item  = res;
               nxt_st.state = io_port_pkg::S_MEMWR;
            end else if (last) begin
               case (st.size)
                  io_port_pkg::SIZE_8:  nxt_st.acc32[7:0]  = res[7:0];
                  io_port_pkg::SIZE_16: nxt_st.acc32[15:0] = res[15:0];
                  default:              nxt_st.acc32       = res;
               endcase
               nxt_st.state = io_port_pkg::S_NEXT;
            end
         end
         io_port_pkg::S_PORTWR, io_port_pkg::S_MEMWR: begin
            if (last) begin
               nxt_st.state = io_port_pkg::S_NEXT;
            end
         end
         io_port_pkg::S_NEXT: begin
            if (st.str && st.we_out) begin
               nxt_st.source_index = st.direction_flag ? st.source_index - {29'h0, nb}
                                                       : st.source_index + {29'h0, nb};
            end else if (st.str) begin
               nxt_st.dest_index = st.direction_flag ? st.dest_index - {29'h0, nb}
                                                     : st.dest_index + {29'h0, nb};
            end
            if (st.str && st.repeat_prefix) begin
               nxt_st.count = st.count - 32'h0000_0001;
            end
            if (st.str && st.repeat_prefix && (st.count != 32'h0000_0001)) begin
               nxt_st.state = first_st;
            end else begin
               nxt_st.state = io_port_pkg::S_IDLE;
               nxt_st.busy  = 1'b0;
               nxt_st.done  = 1'b1;
            end
         end
         default: begin
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         st       <= '0;
         st.state <= io_port_pkg::S_IDLE;
      end else begin
         st <= nxt_st;
      end
   end

   assign prdata  = st.prdata;
   assign pready  = st.pready;
   assign pslverr = st.pslverr;
   assign bus_out = st.bus;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   sequence s_ack_seen;
      st.bus.req && in_s.ack;
   endsequence

   sequence s_req_drop;
      !st.bus.req;
   endsequence

   AST_RELEASE_AFTER_ACK: assert property (s_ack_seen |=> s_req_drop)
      else $error("bus request held after acknowledge");
   AST_DONE_NO_BUS: assert property ($fell(st.busy) |-> !st.bus.req &&
                                     $past(!st.bus.req || in_s.ack))
      else $error("done reported with a bus cycle outstanding");
   AST_PORT_IS_IO: assert property (st.bus.req && (st.state == io_port_pkg::S_PORTRD ||
                                    st.state == io_port_pkg::S_PORTWR) |-> !st.bus.mem_io)
      else $error("port cycle marked as memory");
   AST_MEM_IS_MEM: assert property (st.bus.req && (st.state == io_port_pkg::S_MEMRD ||
                                    st.state == io_port_pkg::S_MEMWR) |-> st.bus.mem_io)
      else $error("memory cycle marked as I/O");
   AST_PORT_RANGE: assert property (st.bus.req && !st.bus.mem_io |-> st.bus.addr[31:16] == 16'h0000)
      else $error("port address beyond 64K space");
   AST_NO_CACHE: assert property ($rose(st.bus.req) && $past(in_s.cache_allow_n) |-> !st.bus.cache_ok)
      else $error("cycle cacheable while cache allow is high");
   AST_IO_UNCACHED: assert property (st.bus.req && (!st.bus.mem_io || st.page_cache_off) |->
                                     !st.bus.cache_ok)
      else $error("port or cache-off cycle marked cacheable");
   AST_SECOND_PART: assert property ($rose(st.bus.req) && st.part |->
                                     st.bus.be[0] && st.bus.addr[1:0] == 2'h0)
      else $error("second split cycle does not start at lane 0");
   AST_PARITY_KEPT: assert property (s_ack_seen ##0 in_s.parity_err |=> st.parity)
      else $error("parity error not reported");
   AST_FAULT_STOPS: assert property ($rose(st.fault) |-> st.state == io_port_pkg::S_IDLE &&
                                     !st.busy && !st.bus.req)
      else $error("fault raised while access continues");
   AST_INDEX_STEP: assert property (st.state == io_port_pkg::S_NEXT && st.str && st.we_out |=>
                                    st.source_index == ($past(st.direction_flag) ?
                                    $past(st.source_index) - {29'h0, $past(nb)} :
                                    $past(st.source_index) + {29'h0, $past(nb)}))
      else $error("source index stepped wrongly");

endmodule

`default_nettype wire

// ==== tb/io_far_side.sv ====
// Far side model: address decode, I/O ports and bitmap memory answering bus cycles
`timescale 1ns/1ps
`default_nettype none
module io_far_side (
   input  wire logic                  mclk,
   input  wire io_port_pkg::bus_out_t bus_out,
   output var  io_port_pkg::bus_in_t  bus_in
);
   logic [2:0]            dly;
   int                    io_cycles;
   io_port_pkg::bus_out_t last_io;
   initial begin
      dly = 3'h0;
      io_cycles = 0;
      last_io = '0;
      bus_in = '0;
   end
   always @(posedge mclk) begin
      // Every range holds devices, so caching is never allowed
      bus_in.cache_allow_n <= 1'b1;
      dly <= bus_out.req ? dly + 3'h1 : 3'h0;
      if (bus_out.req && dly == 3'h3 && !bus_in.ack) begin
         bus_in.ack <= 1'b1;
         // The port word at 60H answers with a parity error
         bus_in.parity_err <= !bus_out.mem_io && bus_out.addr == 32'h0000_0060;
         // Memory answers all ones so any bitmap lookup denies
         bus_in.rdata <= bus_out.mem_io ? 32'hFFFF_FFFF : bus_out.addr ^ 32'h5A5A_5A5A;
         if (!bus_out.mem_io) begin
            io_cycles <= io_cycles + 1;
            last_io <= bus_out;
         end
      end else if (!bus_out.req && bus_in.ack) begin
         bus_in.ack <= 1'b0;
         // Released data lines do not keep the old value
         bus_in.rdata <= ~bus_in.rdata;
      end
   end
endmodule
`default_nettype wire

// ==== tb/io_port_access_unit_tb.sv ====
// Testbench for the I/O port access unit
`timescale 1ns/1ps
`default_nettype none
module io_port_access_unit_tb;
   logic mclk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, serr;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr;
   io_port_pkg::bus_in_t  bus_in;
   io_port_pkg::bus_out_t bus_out;
   int bad_count = 0, n_checks = 0, cyc = 0, n0;
   io_port_access_unit dut (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .bus_in(bus_in), .bus_out(bus_out));
   io_far_side far (.mclk(mclk), .bus_out(bus_out), .bus_in(bus_in));
   always #4 mclk = ~mclk;
   task end_of_test;
      if (bad_count == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         end_of_test;
      end
   end
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         $display("unexpected %s expected %h seen %h", nm, e, g);
         bad_count++;
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      rd = prdata;
      serr = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   task wait_end;
      // Only the cycle ceiling ends a command that never finishes
      do apb(1'b0, io_port_pkg::STATUS_OFS, 32'h0);
      while (rd[2:1] === 2'b00);
   endtask
   initial begin
      repeat (16) @(posedge mclk);
      rst_n <= 1'b1;
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped err", 32'h1, {31'h0, serr});
      chk("unmapped data", 32'h0, rd);
      apb(1'b1, io_port_pkg::ACC_OFS, 32'h1122_3344);
      apb(1'b1, io_port_pkg::PORT_OFS, 32'h0000_0061);
      apb(1'b1, io_port_pkg::CTRL_OFS, 32'h0000_0003);
      wait_end;
      chk("out done", 32'h1, {31'h0, rd[1]});
      chk("parity", 32'h1, {31'h0, rd[3]});
      chk("out addr", 32'h60, far.last_io.addr);
      chk("out sel", 32'h0, {31'h0, far.last_io.mem_io});
      chk("out lanes", 32'h2, {28'h0, far.last_io.be});
      chk("out byte", 32'h44, {24'h0, far.last_io.wdata[15:8]});
      apb(1'b1, io_port_pkg::STATUS_OFS, 32'h0000_000E);
      n0 = far.io_cycles;
      apb(1'b1, io_port_pkg::PORT_OFS, 32'h0063_0000);
      apb(1'b1, io_port_pkg::CTRL_OFS, 32'h0000_0045);
      wait_end;
      chk("split cycles", 32'h2, 32'(far.io_cycles - n0));
      apb(1'b0, io_port_pkg::ACC_OFS, 32'h0);
      chk("in acc16", 32'h1122_3E5A, rd);
      apb(1'b1, io_port_pkg::STATUS_OFS, 32'h0000_000E);
      n0 = far.io_cycles;
      apb(1'b1, io_port_pkg::FLAGS_OFS, 32'h0000_0038);
      apb(1'b1, io_port_pkg::TSB_MAP_OFS, 32'h00FF_0000);
      apb(1'b1, io_port_pkg::CTRL_OFS, 32'h0000_0003);
      wait_end;
      chk("fault", 32'h2, {30'h0, rd[2:1]});
      chk("no io cycle", 32'h0, 32'(far.io_cycles - n0));
      apb(1'b1, io_port_pkg::STATUS_OFS, 32'h0000_000E);
      n0 = far.io_cycles;
      apb(1'b1, io_port_pkg::FLAGS_OFS, 32'h0000_0001);
      apb(1'b1, io_port_pkg::SRC_SEG_OFS, 32'h0000_0100);
      apb(1'b1, io_port_pkg::SRC_IDX_OFS, 32'h0000_0011);
      apb(1'b1, io_port_pkg::COUNT_OFS, 32'h0000_0002);
      apb(1'b1, io_port_pkg::PORT_OFS, 32'h0000_0040);
      apb(1'b1, io_port_pkg::CTRL_OFS, 32'h0000_0033);
      wait_end;
      chk("str done", 32'h1, {31'h0, rd[1]});
      chk("str cycles", 32'h2, 32'(far.io_cycles - n0));
      chk("str byte", 32'hFF, {24'h0, far.last_io.wdata[7:0]});
      chk("str lanes", 32'h1, {28'h0, far.last_io.be});
      apb(1'b0, io_port_pkg::SRC_IDX_OFS, 32'h0);
      chk("src index", 32'h0000_000F, rd);
      apb(1'b0, io_port_pkg::COUNT_OFS, 32'h0);
      chk("count", 32'h0, rd);
      end_of_test;
   end
endmodule
`default_nettype wire
